// File: inc/gtoc_defs.svh
/*
  Constants of the genlock timing offset control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 32-bit APB slave clocked by pclk at 25 MHz.
*/
//
// Function
// (R1) standard is set by software, NTSC or PAL-B; never auto-detected
// (R2) genlock mode picks locked-to-reference or free running
// (R3) frame offset 0-1 NTSC, 0-3 PAL-B, default zero
// (R4) line offset 0-524 NTSC, 0-624 PAL-B, default zero
// (R5) pixel offset in half pixels, up to 857.5 / 863.5, default zero
// (R6) AES frame offset 0-4 in NTSC only; PAL-B forces zero
// (R7) recall defaults sets every offset to zero for the standard
// (R8) locate flashes link and setup LEDs three times, then long off
// (R9) status shows standard, mode, reference, colour and AES lock
// (R10) remote lockout jumper gates remote configuration writes
// (R11) module and input names stored in on-block memory
// (R12) jumper local rejects config writes, lights lockout LED, reads stay
// (R13) output timing counts on the 27 MHz reference clock
// (R14) pulse stream carries field pulse, frame, colour frame, AES bits
// (R15) frame, line, pixel offsets merge into one total delay
`ifndef GTOC_DEFS_SVH
`define GTOC_DEFS_SVH

// register byte addresses
`define GTOC_CTRL_ADDR 12'h000
`define GTOC_FRAME_OFS_ADDR 12'h004
`define GTOC_LINE_OFS_ADDR 12'h008
`define GTOC_PIXEL_OFS_ADDR 12'h00c
`define GTOC_AES_OFS_ADDR 12'h010
`define GTOC_STATUS_ADDR 12'h014
`define GTOC_IRQ_STAT_ADDR 12'h018
`define GTOC_IRQ_MASK_ADDR 12'h01c
`define GTOC_DELAY_ADDR 12'h020
`define GTOC_NAME_BASE 12'h100
`define GTOC_NAME_END 12'h17f

// control fields
`define GTOC_CTRL_STD_BIT 0
`define GTOC_CTRL_GENLOCK_BIT 1
`define GTOC_CTRL_LOCATE_BIT 2
`define GTOC_CTRL_RECALL_BIT 3
`define GTOC_CTRL_RESET 32'h0000_0002

// status fields
`define GTOC_ST_STD_BIT 0
`define GTOC_ST_GENLOCK_BIT 1
`define GTOC_ST_REF_PRES_BIT 2
`define GTOC_ST_REF_LOCK_BIT 3
`define GTOC_ST_CF_LOCK_BIT 4
`define GTOC_ST_AES_LOCK_BIT 5
`define GTOC_ST_LOCKOUT_BIT 6

// interrupt status bits
`define GTOC_IRQ_REF_LOST 0
`define GTOC_IRQ_LOCK_CHG 1
`define GTOC_IRQ_REJECT 2

// offset limits
`define GTOC_FRAME_MAX_NTSC 2'd1
`define GTOC_FRAME_MAX_PAL 2'd3
`define GTOC_LINE_MAX_NTSC 10'd524
`define GTOC_LINE_MAX_PAL 10'd624
`define GTOC_HPIX_MAX_NTSC 11'd1715
`define GTOC_HPIX_MAX_PAL 11'd1727
`define GTOC_AES_MAX_NTSC 3'd4
`define GTOC_LINES_NTSC 19'd525
`define GTOC_LINES_PAL 19'd625
`define GTOC_HPIX_NTSC 32'd1716
`define GTOC_HPIX_PAL 32'd1728
`define GTOC_OFS_RESET 32'h0000_0000

// locate blink timing in ms, pclk rate in kHz
`define GTOC_BLINK_ON_MS 200
`define GTOC_BLINK_OFF_MS 1200
`define GTOC_CLK_KHZ 25000

`endif

// File: inc/gtoc_pkg.sv
/*
  Types of the genlock timing offset control block.
  Assumes gtoc_defs.svh supplies the numeric constants.
*/
package gtoc_pkg;
  typedef enum logic [0:0] {
    gtoc_std_ntsc = 1'b0,
    gtoc_std_pal = 1'b1
  } gtoc_std_t;

  typedef enum logic [3:0] {
    gtoc_loc_idle = 4'b0001,
    gtoc_loc_on = 4'b0010,
    gtoc_loc_gap = 4'b0100,
    gtoc_loc_rest = 4'b1000
  } gtoc_loc_t;
endpackage : gtoc_pkg

// File: rtl/gtoc_locate.sv
/*
  Locate blinker: three on flashes then a long off interval, repeating.
  Assumes enable comes from pclk-domain logic.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gtoc_defs.svh"
module gtoc_locate #(
  parameter int ON_CYCLES = `GTOC_BLINK_ON_MS * `GTOC_CLK_KHZ,
  parameter int OFF_CYCLES = `GTOC_BLINK_OFF_MS * `GTOC_CLK_KHZ
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic enable,
  // led drive
  output logic blink
);
  import gtoc_pkg::*;

  gtoc_loc_t state;
  gtoc_loc_t next_state;
  logic [31:0] count;
  logic [31:0] next_count;
  logic [1:0] flashes;
  logic [1:0] next_flashes;
  logic next_blink;

  ////////////////////////////////////////////////////////////////////////
  // flash sequencer
  always_comb begin
    next_state = state;
    next_count = count + 32'd1;
    next_flashes = flashes;
    next_blink = 1'b0;
    unique case (state)
      gtoc_loc_idle: begin
        next_count = 32'd0;
        next_flashes = 2'd0;
        if (enable) begin
          next_state = gtoc_loc_on;
        end
      end
      gtoc_loc_on: begin
        next_blink = 1'b1; // see (R8)
        if (count >= ON_CYCLES - 1) begin
          next_count = 32'd0;
          next_flashes = flashes + 2'd1;
          next_state = (flashes == 2'd2) ? gtoc_loc_rest : gtoc_loc_gap;
        end
      end
      gtoc_loc_gap: begin
        if (count >= ON_CYCLES - 1) begin
          next_count = 32'd0;
          next_state = gtoc_loc_on;
        end
      end
      gtoc_loc_rest: begin
        // long dark interval marks the end of a group
        if (count >= OFF_CYCLES - 1) begin
          next_count = 32'd0;
          next_flashes = 2'd0;
          next_state = gtoc_loc_on;
        end
      end
      default: begin
        next_state = gtoc_loc_idle;
      end
    endcase
    if (!enable) begin
      next_state = gtoc_loc_idle;
      next_blink = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= gtoc_loc_idle;
      count <= 32'd0;
      flashes <= 2'd0;
      blink <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      flashes <= next_flashes;
      blink <= next_blink;
    end
  end
endmodule : gtoc_locate
`default_nettype wire

// File: rtl/gtoc_ctrl.sv
/*
  Genlock timing offset control: APB register file, offset clamping,
  total delay, status, interrupts, names memory and indicators.
  Assumes analog lock logic drives the ref/lock inputs asynchronously and
  the timing generator consumes total_delay and offsets on the 27 MHz side.
*/
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "gtoc_defs.svh"
module gtoc_ctrl #(
  parameter int NAME_WORDS = 32,
  parameter int BLINK_ON = `GTOC_BLINK_ON_MS * `GTOC_CLK_KHZ,
  parameter int BLINK_OFF = `GTOC_BLINK_OFF_MS * `GTOC_CLK_KHZ
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins
  input wire logic remote_lockout_jumper,
  input wire logic ref_present_in,
  input wire logic ref_locked_in,
  input wire logic colour_lock_in,
  input wire logic aes_lock_in,
  // timing generator settings
  output gtoc_pkg::gtoc_std_t std_sel,
  output logic genlock_en,
  output logic [1:0] frame_offset,
  output logic [9:0] line_offset,
  output logic [10:0] half_pixel_offset,
  output logic [2:0] aes_offset,
  output logic [31:0] total_delay,
  // indicators
  output logic link_activity_led,
  output logic setup_in_progress_led,
  output logic lockout_led,
  output logic irq
);
  import gtoc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two stages each
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {remote_lockout_jumper, ref_present_in, ref_locked_in,
                   colour_lock_in, aes_lock_in};
      pin_sync <= pin_meta;
    end
  end
  logic local_mode;
  logic ref_pres;
  logic ref_lock;
  logic cf_lock;
  logic aes_lock;
  // jumper high means local position
  assign local_mode = pin_sync[4];
  assign ref_pres = pin_sync[3];
  assign ref_lock = pin_sync[2];
  assign cf_lock = pin_sync[1];
  assign aes_lock = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // clamp helpers, each used on write and on standard change
  function automatic logic [1:0] clamp_frame(input logic [31:0] v, input gtoc_std_t s);
    logic [1:0] lim;
    lim = (s == gtoc_std_pal) ? `GTOC_FRAME_MAX_PAL : `GTOC_FRAME_MAX_NTSC;
    clamp_frame = (v > {30'd0, lim}) ? lim : v[1:0]; // see (R3)
  endfunction : clamp_frame

  function automatic logic [9:0] clamp_line(input logic [31:0] v, input gtoc_std_t s);
    logic [9:0] lim;
    lim = (s == gtoc_std_pal) ? `GTOC_LINE_MAX_PAL : `GTOC_LINE_MAX_NTSC;
    clamp_line = (v > {22'd0, lim}) ? lim : v[9:0]; // see (R4)
  endfunction : clamp_line

  function automatic logic [10:0] clamp_pix(input logic [31:0] v, input gtoc_std_t s);
    logic [10:0] lim;
    lim = (s == gtoc_std_pal) ? `GTOC_HPIX_MAX_PAL : `GTOC_HPIX_MAX_NTSC;
    clamp_pix = (v > {21'd0, lim}) ? lim : v[10:0]; // see (R5)
  endfunction : clamp_pix

  function automatic logic [2:0] clamp_aes(input logic [31:0] v, input gtoc_std_t s);
    // pal carries no adjustable aes phase
    if (s == gtoc_std_pal) begin
      clamp_aes = 3'd0; // see (R6)
    end else begin
      clamp_aes = (v > {29'd0, `GTOC_AES_MAX_NTSC}) ? `GTOC_AES_MAX_NTSC : v[2:0];
    end
  endfunction : clamp_aes

  ////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states
  logic wr_acc;
  logic cfg_addr;
  logic name_addr;
  logic mapped;
  logic cfg_wr;
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign name_addr = (paddr >= `GTOC_NAME_BASE) && (paddr <= `GTOC_NAME_END);
  assign cfg_addr = (paddr == `GTOC_CTRL_ADDR) || (paddr == `GTOC_FRAME_OFS_ADDR) ||
                    (paddr == `GTOC_LINE_OFS_ADDR) || (paddr == `GTOC_PIXEL_OFS_ADDR) ||
                    (paddr == `GTOC_AES_OFS_ADDR) || name_addr;
  assign mapped = cfg_addr || (paddr == `GTOC_STATUS_ADDR) ||
                  (paddr == `GTOC_IRQ_STAT_ADDR) || (paddr == `GTOC_IRQ_MASK_ADDR) ||
                  (paddr == `GTOC_DELAY_ADDR);
  // configuration write only accepted with the jumper in remote
  assign cfg_wr = wr_acc && cfg_addr && !local_mode; // see (R10) (R12)
  assign pslverr = psel && penable && (!mapped || (wr_acc && cfg_addr && local_mode));

  ////////////////////////////////////////////////////////////////////////
  // settings registers
  logic next_std_pal;
  logic next_genlock;
  logic next_locate;
  logic [1:0] next_frame;
  logic [9:0] next_line;
  logic [10:0] next_hpix;
  logic [2:0] next_aes;
  logic locate_en;
  logic std_pal;
  gtoc_std_t std_new;
  always_comb begin
    next_std_pal = std_pal;
    next_genlock = genlock_en;
    next_locate = locate_en;
    next_frame = frame_offset;
    next_line = line_offset;
    next_hpix = half_pixel_offset;
    next_aes = aes_offset;
    if (cfg_wr && paddr == `GTOC_CTRL_ADDR) begin
      next_std_pal = pwdata[`GTOC_CTRL_STD_BIT]; // see (R1)
      next_genlock = pwdata[`GTOC_CTRL_GENLOCK_BIT]; // see (R2)
      next_locate = pwdata[`GTOC_CTRL_LOCATE_BIT];
    end
    std_new = next_std_pal ? gtoc_std_pal : gtoc_std_ntsc;
    // re-clamp on standard change so limits never go stale
    next_frame = clamp_frame({30'd0, next_frame}, std_new);
    next_line = clamp_line({22'd0, next_line}, std_new);
    next_hpix = clamp_pix({21'd0, next_hpix}, std_new);
    next_aes = clamp_aes({29'd0, next_aes}, std_new);
    if (cfg_wr) begin
      if (paddr == `GTOC_FRAME_OFS_ADDR) begin
        next_frame = clamp_frame(pwdata, std_new);
      end
      if (paddr == `GTOC_LINE_OFS_ADDR) begin
        next_line = clamp_line(pwdata, std_new);
      end
      if (paddr == `GTOC_PIXEL_OFS_ADDR) begin
        next_hpix = clamp_pix(pwdata, std_new);
      end
      if (paddr == `GTOC_AES_OFS_ADDR) begin
        next_aes = clamp_aes(pwdata, std_new);
      end
    end
    if (cfg_wr && paddr == `GTOC_CTRL_ADDR && pwdata[`GTOC_CTRL_RECALL_BIT]) begin
      next_frame = 2'd0; // see (R7)
      next_line = 10'd0;
      next_hpix = 11'd0;
      next_aes = 3'd0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_pal <= 1'b0;
      genlock_en <= 1'b1;
      locate_en <= 1'b0;
      frame_offset <= 2'd0;
      line_offset <= 10'd0;
      half_pixel_offset <= 11'd0;
      aes_offset <= 3'd0;
    end else begin
      std_pal <= next_std_pal;
      genlock_en <= next_genlock;
      locate_en <= next_locate;
      frame_offset <= next_frame;
      line_offset <= next_line;
      half_pixel_offset <= next_hpix;
      aes_offset <= next_aes; // see (R14)
    end
  end
  assign std_sel = std_pal ? gtoc_std_pal : gtoc_std_ntsc;

  ////////////////////////////////////////////////////////////////////////
  // total delay in half-pixel units of the 27 MHz timebase
  logic [31:0] next_total;
  logic [31:0] lines_fr;
  logic [31:0] hpix_ln;
  always_comb begin
    lines_fr = std_pal ? {13'd0, `GTOC_LINES_PAL} : {13'd0, `GTOC_LINES_NTSC};
    hpix_ln = std_pal ? `GTOC_HPIX_PAL : `GTOC_HPIX_NTSC;
    // one sum keeps the whole pulse stream moving together
    next_total = (({30'd0, frame_offset} * lines_fr + {22'd0, line_offset}) * hpix_ln)
                 + {21'd0, half_pixel_offset}; // see (R15) (R13)
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_delay <= 32'd0;
    end else begin
      total_delay <= next_total;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // names memory; kept on the block, not reset
  logic [31:0] name_mem [NAME_WORDS];
  logic [4:0] name_idx;
  assign name_idx = paddr[6:2];
  always_ff @(posedge pclk) begin
    if (cfg_wr && name_addr) begin
      name_mem[name_idx] <= pwdata; // see (R11)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set beats clear
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] next_stat;
  logic [2:0] next_mask;
  logic [2:0] ev;
  logic ref_lock_d;
  logic ref_pres_d;
  always_comb begin
    ev[`GTOC_IRQ_REF_LOST] = ref_pres_d && !ref_pres;
    ev[`GTOC_IRQ_LOCK_CHG] = ref_lock_d != ref_lock;
    ev[`GTOC_IRQ_REJECT] = wr_acc && cfg_addr && local_mode;
    next_stat = irq_stat;
    next_mask = irq_mask;
    if (wr_acc && paddr == `GTOC_IRQ_STAT_ADDR) begin
      next_stat = irq_stat & ~pwdata[2:0];
    end
    if (wr_acc && paddr == `GTOC_IRQ_MASK_ADDR) begin
      next_mask = pwdata[2:0];
    end
    next_stat = next_stat | ev;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'd0;
      irq_mask <= 3'd0;
      ref_lock_d <= 1'b0;
      ref_pres_d <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      irq_mask <= next_mask;
      ref_lock_d <= ref_lock;
      ref_pres_d <= ref_pres;
      irq <= |(next_stat & next_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  always_comb begin
    status_word = 32'd0;
    status_word[`GTOC_ST_STD_BIT] = std_pal; // see (R9)
    status_word[`GTOC_ST_GENLOCK_BIT] = genlock_en;
    status_word[`GTOC_ST_REF_PRES_BIT] = ref_pres;
    status_word[`GTOC_ST_REF_LOCK_BIT] = ref_lock && genlock_en;
    status_word[`GTOC_ST_CF_LOCK_BIT] = cf_lock && genlock_en;
    status_word[`GTOC_ST_AES_LOCK_BIT] = aes_lock && genlock_en;
    status_word[`GTOC_ST_LOCKOUT_BIT] = local_mode;
    next_rdata = 32'd0;
    if (psel && !penable && !pwrite) begin
      if (name_addr) begin
        next_rdata = name_mem[name_idx];
      end else begin
        unique case (paddr)
          `GTOC_CTRL_ADDR: next_rdata = {28'd0, 1'b0, locate_en, genlock_en, std_pal};
          `GTOC_FRAME_OFS_ADDR: next_rdata = {30'd0, frame_offset};
          `GTOC_LINE_OFS_ADDR: next_rdata = {22'd0, line_offset};
          `GTOC_PIXEL_OFS_ADDR: next_rdata = {21'd0, half_pixel_offset};
          `GTOC_AES_OFS_ADDR: next_rdata = {29'd0, aes_offset};
          `GTOC_STATUS_ADDR: next_rdata = status_word;
          `GTOC_IRQ_STAT_ADDR: next_rdata = {29'd0, irq_stat};
          `GTOC_IRQ_MASK_ADDR: next_rdata = {29'd0, irq_mask};
          `GTOC_DELAY_ADDR: next_rdata = total_delay;
          default: next_rdata = 32'd0;
        endcase
      end
    end else if (psel && penable) begin
      next_rdata = prdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'd0;
    end else begin
      prdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indicators
  logic blink;
  gtoc_locate #(
    .ON_CYCLES(BLINK_ON),
    .OFF_CYCLES(BLINK_OFF)
  ) u_locate (
    .pclk(pclk),
    .presetn(presetn),
    .enable(locate_en),
    .blink(blink)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_activity_led <= 1'b0;
      setup_in_progress_led <= 1'b0;
      lockout_led <= 1'b0;
    end else begin
      link_activity_led <= blink || (psel && !locate_en); // see (R8)
      setup_in_progress_led <= blink;
      lockout_led <= local_mode; // see (R12)
    end
  end
endmodule : gtoc_ctrl
`default_nettype wire

// File: tb/gtoc_ctrl_properties.sv
/*
  Port checker for the genlock timing offset control block.
  Assumes one pclk domain and a bind onto gtoc_ctrl.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gtoc_defs.svh"
module gtoc_ctrl_properties import gtoc_pkg::*; (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // pins and settings
  input wire logic remote_lockout_jumper,
  input wire gtoc_pkg::gtoc_std_t std_sel,
  input wire logic genlock_en,
  input wire logic [1:0] frame_offset,
  input wire logic [9:0] line_offset,
  input wire logic [10:0] half_pixel_offset,
  input wire logic [2:0] aes_offset,
  input wire logic [31:0] total_delay,
  input wire logic lockout_led
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] delay_calc;
  logic acc_wr;
  logic pal;
  // delay from present settings; design shows it a cycle later
  always_comb begin
    pal = (std_sel == gtoc_std_pal);
    delay_calc = (32'(frame_offset) * (pal ? `GTOC_LINES_PAL : `GTOC_LINES_NTSC)
      + 32'(line_offset)) * (pal ? `GTOC_HPIX_PAL : `GTOC_HPIX_NTSC) + 32'(half_pixel_offset);
  end
  assign acc_wr = psel && penable && pwrite;
  // jumper settled long enough to pass the synchroniser
  sequence s_locked;
    remote_lockout_jumper [*5];
  endsequence
  sequence s_open;
    !remote_lockout_jumper [*5];
  endsequence
  ////////////////////////////////////////////////////////////////////
  chk_ctrl_write: assert property (
    s_open ##0 (acc_wr && paddr == `GTOC_CTRL_ADDR) |=> std_sel == $past(pwdata[0])
      && genlock_en == $past(pwdata[1]))
    else $error("standard or genlock mode not taken from write");
  chk_frame_clamp: assert property (
    frame_offset <= (pal ? `GTOC_FRAME_MAX_PAL : `GTOC_FRAME_MAX_NTSC))
    else $error("frame offset above limit");
  chk_line_clamp: assert property (
    line_offset <= (pal ? `GTOC_LINE_MAX_PAL : `GTOC_LINE_MAX_NTSC))
    else $error("line offset above limit");
  chk_pixel_clamp: assert property (
    half_pixel_offset <= (pal ? `GTOC_HPIX_MAX_PAL : `GTOC_HPIX_MAX_NTSC))
    else $error("pixel offset above limit");
  chk_aes_pal_zero: assert property (
    pal |-> aes_offset == 3'h0)
    else $error("aes offset nonzero in pal");
  chk_recall_zero: assert property (
    s_open ##0 (acc_wr && paddr == `GTOC_CTRL_ADDR && pwdata[3]) |=>
      frame_offset == 2'h0 && line_offset == 10'h0 && half_pixel_offset == 11'h0
      && aes_offset == 3'h0)
    else $error("recall left an offset set");
  chk_delay_sum: assert property (
    total_delay == $past(delay_calc))
    else $error("total delay does not match offsets");
  chk_locked_err: assert property (
    s_locked ##0 (acc_wr && paddr == `GTOC_LINE_OFS_ADDR) |-> pslverr)
    else $error("locked out write not refused");
  chk_locked_hold: assert property (
    s_locked ##0 (acc_wr && paddr == `GTOC_LINE_OFS_ADDR) |=> $stable(line_offset))
    else $error("locked out write changed line offset");
  chk_lockout_led: assert property (
    $rose(remote_lockout_jumper) |-> ##[2:4] lockout_led)
    else $error("lockout led late");
  chk_unmapped_err: assert property (
    psel && penable && paddr == 12'h024 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  // main scenarios seen
  cover property (s_open ##0 (acc_wr && paddr == `GTOC_CTRL_ADDR && pwdata[3]));
  cover property (s_locked ##0 (acc_wr && paddr == `GTOC_LINE_OFS_ADDR));
  cover property ($rose(lockout_led));
endmodule : gtoc_ctrl_properties

bind gtoc_ctrl gtoc_ctrl_properties u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .remote_lockout_jumper, .std_sel, .genlock_en, .frame_offset, .line_offset,
  .half_pixel_offset, .aes_offset, .total_delay, .lockout_led
);
`default_nettype wire

// File: tb/gtoc_ref_model.sv
/*
  Behavioural reference front end: presence and lock status lines.
  Assumes the bench switches the feed on or off on pclk edges.
*/
`timescale 1ns/100ps
`default_nettype none
module gtoc_ref_model #(
  parameter int LOCK_DLY = 6
) (
  // clock and feed control
  input wire logic pclk,
  input wire logic feed_on,
  // status lines towards the block
  output logic ref_present_in,
  output logic ref_locked_in,
  output logic colour_lock_in,
  output logic aes_lock_in
);
  int unsigned held = 0;
  // lock follows the feed after LOCK_DLY edges, drops at once
  always @(posedge pclk) begin
    if (!feed_on) begin
      held <= 0;
    end else if (held < LOCK_DLY) begin
      held <= held + 1;
    end
  end
  assign ref_present_in = feed_on;
  assign ref_locked_in = feed_on && (held >= LOCK_DLY);
  assign colour_lock_in = ref_locked_in;
  assign aes_lock_in = ref_locked_in;
endmodule : gtoc_ref_model
`default_nettype wire

// File: tb/gtoc_ctrl_test.sv
/*
  Self-checking bench of the offset control block over APB.
  Assumes the design and checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gtoc_defs.svh"
module gtoc_ctrl_test;
  import gtoc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic remote_lockout_jumper = 1'b0;
  logic feed_on = 1'b1;
  logic [31:0] prdata, total_delay, rdat;
  logic pready, pslverr, rerr, genlock_en, irq, lockout_led;
  logic ref_present_in, ref_locked_in, colour_lock_in, aes_lock_in;
  logic link_activity_led, setup_in_progress_led;
  logic [1:0] frame_offset;
  logic [9:0] line_offset;
  logic [10:0] half_pixel_offset;
  logic [2:0] aes_offset;
  gtoc_std_t std_sel;
  int failures = 0;
  int cmp_count = 0;
  int n, hi, hl;
  logic [31:0] lim_ntsc [4] = '{32'(`GTOC_FRAME_MAX_NTSC), 32'(`GTOC_LINE_MAX_NTSC),
    32'(`GTOC_HPIX_MAX_NTSC), 32'(`GTOC_AES_MAX_NTSC)};
  logic [31:0] lim_pal [4] = '{32'(`GTOC_FRAME_MAX_PAL), 32'(`GTOC_LINE_MAX_PAL),
    32'(`GTOC_HPIX_MAX_PAL), 32'h0};

  // short blink counts keep the locate run brief
  gtoc_ctrl #(.BLINK_ON(4), .BLINK_OFF(10)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .remote_lockout_jumper, .ref_present_in, .ref_locked_in, .colour_lock_in,
    .aes_lock_in, .std_sel, .genlock_en, .frame_offset, .line_offset, .half_pixel_offset,
    .aes_offset, .total_delay, .link_activity_led, .setup_in_progress_led, .lockout_led, .irq
  );
  gtoc_ref_model #(.LOCK_DLY(6)) u_ref (
    .pclk, .feed_on, .ref_present_in, .ref_locked_in, .colour_lock_in, .aes_lock_in
  );
  always #20 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk
  // one transfer; answer taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("pready", 32'h1, 32'(pready));
      end_sim();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask : rd
  function automatic logic [31:0] full_delay(input int pal);
    if (pal != 0) begin
      return (lim_pal[0] * `GTOC_LINES_PAL + lim_pal[1]) * `GTOC_HPIX_PAL + lim_pal[2];
    end
    return (lim_ntsc[0] * `GTOC_LINES_NTSC + lim_ntsc[1]) * `GTOC_HPIX_NTSC + lim_ntsc[2];
  endfunction : full_delay
  ////////////////////////////////////////////////////////////////////
  // watchdog against a hang anywhere
  initial begin
    repeat (20000) @(posedge pclk);
    chk("watchdog", 32'h0, 32'h1);
    end_sim();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("genlock_en", 32'h1, 32'(genlock_en));
    rd("ctrl", `GTOC_CTRL_ADDR, `GTOC_CTRL_RESET);
    for (int i = 1; i < 5; i++) begin
      rd("offset", 12'(4 * i), 32'h0);
    end
    // saturating writes per standard, then the delay
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `GTOC_CTRL_ADDR, 32'(2 + s));
      chk("std_sel", 32'(s), 32'(std_sel));
      for (int i = 1; i < 5; i++) begin
        apb(1'b1, 12'(4 * i), 32'hffff_ffff);
        rd("offset", 12'(4 * i), s ? lim_pal[i - 1] : lim_ntsc[i - 1]);
      end
      rd("delay", `GTOC_DELAY_ADDR, full_delay(s));
    end
    apb(1'b1, `GTOC_CTRL_ADDR, 32'h2);
    rd("line", `GTOC_LINE_OFS_ADDR, lim_ntsc[1]);
    rd("status", `GTOC_STATUS_ADDR, 32'h3e);
    apb(1'b1, `GTOC_CTRL_ADDR, 32'h0);
    chk("genlock_en", 32'h0, 32'(genlock_en));
    rd("status", `GTOC_STATUS_ADDR, 32'h04);
    apb(1'b1, `GTOC_CTRL_ADDR, 32'h0a);
    for (int i = 1; i < 5; i++) begin
      rd("offset", 12'(4 * i), 32'h0);
    end
    rd("ctrl", `GTOC_CTRL_ADDR, 32'h2);
    apb(1'b1, `GTOC_NAME_BASE, 32'h1234_abcd);
    apb(1'b1, 12'h17c, 32'h5a5a_0ff0);
    rd("name", `GTOC_NAME_BASE, 32'h1234_abcd);
    rd("name", 12'h17c, 32'h5a5a_0ff0);
    rd("unmapped", 12'h024, 32'h0);
    chk("pslverr", 32'h1, 32'(rerr));
    // locate: three flashes of 4 within a 30-cycle pattern
    apb(1'b1, `GTOC_CTRL_ADDR, 32'h6);
    n = 0;
    hi = 0;
    hl = 0;
    while (setup_in_progress_led !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    repeat (30) begin
      hi += 32'(setup_in_progress_led);
      hl += 32'(link_activity_led);
      @(negedge pclk);
    end
    chk("setup led on", 32'd12, 32'(hi));
    chk("link led on", 32'd12, 32'(hl));
    apb(1'b1, `GTOC_CTRL_ADDR, 32'h2);
    // lockout, refused write and rejected-write interrupt
    apb(1'b1, `GTOC_IRQ_STAT_ADDR, 32'hffff_ffff);
    remote_lockout_jumper <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("lockout_led", 32'h1, 32'(lockout_led));
    apb(1'b1, `GTOC_LINE_OFS_ADDR, 32'h5);
    chk("pslverr", 32'h1, 32'(rerr));
    rd("line", `GTOC_LINE_OFS_ADDR, 32'h0);
    rd("status", `GTOC_STATUS_ADDR, 32'h7e);
    rd("irq stat", `GTOC_IRQ_STAT_ADDR, 32'h4);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, `GTOC_IRQ_MASK_ADDR, 32'h4);
    rd("irq mask", `GTOC_IRQ_MASK_ADDR, 32'h4);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, `GTOC_IRQ_STAT_ADDR, 32'h4);
    rd("irq stat", `GTOC_IRQ_STAT_ADDR, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    // reference lost while unmasked
    remote_lockout_jumper <= 1'b0;
    apb(1'b1, `GTOC_IRQ_MASK_ADDR, 32'h1);
    feed_on <= 1'b0;
    repeat (6) @(posedge pclk);
    rd("irq stat", `GTOC_IRQ_STAT_ADDR, 32'h3);
    chk("irq", 32'h1, 32'(irq));
    rd("status", `GTOC_STATUS_ADDR, 32'h02);
    end_sim();
  end
endmodule : gtoc_ctrl_test
`default_nettype wire
